// ---- rtl/pfds_pkg.sv ----
// package: register map, field layout, reset values and bus widths of the pin function block
package pfds_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int NUM_REGS = 16;
    // register indices; byte address is four times the index
    localparam logic [3:0] IDX_DRIVE_LEVEL_CTRL_2     = 4'h0;
    localparam logic [3:0] IDX_DRIVE_LEVEL_CTRL_3     = 4'h1;
    localparam logic [3:0] IDX_PORTA_FUNC_SELECT_LOW  = 4'h2;
    localparam logic [3:0] IDX_PORTA_FUNC_SELECT_HIGH = 4'h3;
    localparam logic [3:0] IDX_PORTB_FUNC_SELECT      = 4'h4;
    localparam logic [3:0] IDX_PORTC_FUNC_SELECT_LOW  = 4'h5;
    localparam logic [3:0] IDX_PORTC_FUNC_SELECT_HIGH = 4'h6;
    localparam logic [3:0] IDX_PORTD_FUNC_SELECT_LOW  = 4'h7;
    localparam logic [3:0] IDX_PORTD_FUNC_SELECT_HIGH = 4'h8;
    localparam logic [3:0] IDX_PORTE_FUNC_SELECT_LOW  = 4'h9;
    localparam logic [3:0] IDX_PORTE_FUNC_SELECT_HIGH = 4'hA;
    localparam logic [3:0] IDX_PORTF_FUNC_SELECT_LOW  = 4'hB;
    localparam logic [3:0] IDX_PORTF_FUNC_SELECT_HIGH = 4'hC;
    localparam logic [3:0] IDX_PORTG_FUNC_SELECT      = 4'hD;
    localparam logic [3:0] IDX_INPUT_SOURCE_SELECT_0  = 4'hE;
    localparam logic [3:0] IDX_INPUT_SOURCE_SELECT_1  = 4'hF;
    // writable bits of each register, index 15 down to 0; the rest read as zero
    localparam logic [NUM_REGS-1:0][7:0] WR_MASK = {
        8'h74, 8'hC9, 8'h3F, 8'hFF, 8'hFF, 8'hFC, 8'h3F, 8'hFF,
        8'hFF, 8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h03, 8'hFF};
    localparam logic [7:0] REG_RESET = 8'h00;
    // drive-level field positions
    localparam int DRV_PF_HI_LSB = 6;
    localparam int DRV_PF_LO_LSB = 4;
    localparam int DRV_PE_HI_LSB = 2;
    localparam int DRV_PE_LO_LSB = 0;
    localparam int DRV_PG_LSB    = 0;
    // port A low selection field positions
    localparam int SEL_PA3_LSB = 6;
    localparam int SEL_PA2_LSB = 4;
    localparam int SEL_PA1_LSB = 2;
    localparam int SEL_PA0_LSB = 0;
    // function codes
    localparam logic [1:0] CODE_0 = 2'h0;
    localparam logic [1:0] CODE_1 = 2'h1;
    localparam logic [1:0] CODE_2 = 2'h2;
    localparam logic [1:0] CODE_3 = 2'h3;
    localparam logic [1:0] DRIVE_OFF = 2'h0;
    localparam int OTHER_SEL_W = 88;
endpackage

// ---- rtl/pfds_pin_mux.sv ----
// pin function multiplexer and drive-level selection with an Avalon-MM register slave
// Behaviour
// - drive register 2 bits 7:6 set port F 7..4
// - drive register 2 bits 5:4 set port F 3..0
// - drive register 2 bits 3:2 set port E 7..4
// - drive register 2 bits 1:0 set port E 3..0
// - drive register 3 bits 1:0 set port G 2..0
// - drive register 3 upper bits read zero
// - port A pin 3 four-way output function select
// - port A pin 2: io/timer clock or crystal
// - port A pin 1: io, lcd, detector, inverted timer
// - port A pin 0: io/capture, timer output, crystal
// - shared digital inputs need pin set input
// - two input source select registers exist
// - per-port two-bit output function select registers
// - drive level only acts on push-pull outputs
// - direction one means input, zero push-pull output
//
// Chosen here: the Avalon-MM register port and the address map.
`timescale 1ns/100ps
module pfds_pin_mux (
    input  wire logic                             ref_clk,
    input  wire logic                             sys_rst,
    input  wire logic [pfds_pkg::ADDR_W-1:0]      address,
    input  wire logic                             read,
    input  wire logic                             write,
    input  wire logic [pfds_pkg::DATA_W-1:0]      writedata,
    output logic      [pfds_pkg::DATA_W-1:0]      readdata,
    output logic                                  waitrequest,
    input  wire logic [3:0]                       portADir,
    input  wire logic [3:0]                       portAOutData,
    input  wire logic [3:0]                       portAPinIn,
    input  wire logic [7:0]                       portEDir,
    input  wire logic [7:0]                       portFDir,
    input  wire logic [2:0]                       portGDir,
    input  wire logic                             timer1Output,
    input  wire logic                             serialDataOut,
    input  wire logic                             oscOutPin,
    input  wire logic                             timer0InvertedOutput,
    input  wire logic                             timer0Output,
    output logic      [3:0]                       portAPadOut,
    output logic      [3:0]                       portAPadOe,
    output logic                                  timer1CaptureInput,
    output logic                                  timer0ClockInput,
    output logic                                  extInterruptInput,
    output logic                                  stdTimerClockInput,
    output logic                                  timer0CaptureInput,
    output logic                                  crystalPinAEn,
    output logic                                  crystalPinBEn,
    output logic                                  lcdSegmentEn,
    output logic                                  lowVoltageDetectEn,
    output logic      [15:0]                      portEDrive,
    output logic      [15:0]                      portFDrive,
    output logic      [5:0]                       portGDrive,
    output logic      [7:0]                       inputSourceSel0,
    output logic      [7:0]                       inputSourceSel1,
    output logic      [pfds_pkg::OTHER_SEL_W-1:0] otherFuncSel
);
    import pfds_pkg::*;

    typedef struct packed {
        logic [NUM_REGS-1:0][7:0] regs;
        logic                     waitReq;
        logic [DATA_W-1:0]        rdData;
        logic [3:0]               padOut;
        logic [3:0]               padOe;
        logic                     t1Cap;
        logic                     t0Clk;
        logic                     extInt;
        logic                     stdClk;
        logic                     t0Cap;
        logic                     xtalA;
        logic                     xtalB;
        logic                     lcdSeg;
        logic                     lvd;
        logic [15:0]              drvE;
        logic [15:0]              drvF;
        logic [5:0]               drvG;
    } pfds_state_t;

    pfds_state_t stateQ;
    pfds_state_t stateD;
    logic [3:0]  regIdx;
    logic        mapped;
    logic [1:0]  selA3;
    logic [1:0]  selA2;
    logic [1:0]  selA1;
    logic [1:0]  selA0;
    logic [7:0]  drv2;
    logic [7:0]  drv3;

    assign regIdx = address[5:2];
    assign mapped = (address[ADDR_W-1:6] == 2'h0);

    // next state: bus slave first, then routing from the new register values so that
    // the pins follow a write in the same edge that stores it
    always_comb begin
        stateD = stateQ;
        stateD.waitReq = 1'b1;
        // first cycle of a request: drop waitrequest and present read data
        if ((read || write) && stateQ.waitReq) begin
            stateD.waitReq = 1'b0;
            stateD.rdData = {24'h000000, (mapped ? stateQ.regs[regIdx] : 8'h00)};
        end
        // write lands on the edge where the master sees waitrequest low
        if (write && !stateQ.waitReq && mapped) begin
            stateD.regs[regIdx] = writedata[7:0] & WR_MASK[regIdx];
        end
        selA3 = stateD.regs[IDX_PORTA_FUNC_SELECT_LOW][SEL_PA3_LSB +: 2];
        selA2 = stateD.regs[IDX_PORTA_FUNC_SELECT_LOW][SEL_PA2_LSB +: 2];
        selA1 = stateD.regs[IDX_PORTA_FUNC_SELECT_LOW][SEL_PA1_LSB +: 2];
        selA0 = stateD.regs[IDX_PORTA_FUNC_SELECT_LOW][SEL_PA0_LSB +: 2];
        drv2 = stateD.regs[IDX_DRIVE_LEVEL_CTRL_2];
        drv3 = stateD.regs[IDX_DRIVE_LEVEL_CTRL_3];
        // default: plain gpio, direction bit one is input, zero is output
        for (int i = 0; i < 4; i++) begin
            stateD.padOe[i] = ~portADir[i];
            stateD.padOut[i] = portAOutData[i] & ~portADir[i];
        end
        stateD.t1Cap = 1'b0;
        stateD.t0Clk = 1'b0;
        stateD.extInt = 1'b0;
        stateD.stdClk = 1'b0;
        stateD.t0Cap = 1'b0;
        stateD.xtalA = 1'b0;
        stateD.xtalB = 1'b0;
        stateD.lcdSeg = 1'b0;
        stateD.lvd = 1'b0;
        // pin 3; shared inputs only see the pin while it is an input
        case (selA3)
            CODE_0: stateD.t1Cap = portAPinIn[3] & portADir[3];
            CODE_1: begin
                stateD.padOe[3] = 1'b1;
                stateD.padOut[3] = timer1Output;
            end
            CODE_2: begin
                stateD.padOe[3] = 1'b1;
                stateD.padOut[3] = serialDataOut;
            end
            default: begin
                stateD.padOe[3] = 1'b1;
                stateD.padOut[3] = oscOutPin;
            end
        endcase
        // pin 2; crystal is analog so the digital driver is released
        if (selA2 == CODE_3) begin
            stateD.padOe[2] = 1'b0;
            stateD.padOut[2] = 1'b0;
            stateD.xtalB = 1'b1;
        end else begin
            stateD.t0Clk = portAPinIn[2] & portADir[2];
        end
        // pin 1
        case (selA1)
            CODE_0: begin
                stateD.extInt = portAPinIn[1] & portADir[1];
                stateD.stdClk = portAPinIn[1] & portADir[1];
            end
            CODE_1: begin
                stateD.padOe[1] = 1'b0;
                stateD.padOut[1] = 1'b0;
                stateD.lcdSeg = 1'b1;
            end
            CODE_2: begin
                stateD.padOe[1] = 1'b0;
                stateD.padOut[1] = 1'b0;
                stateD.lvd = 1'b1;
            end
            default: begin
                stateD.padOe[1] = 1'b1;
                stateD.padOut[1] = timer0InvertedOutput;
            end
        endcase
        // pin 0
        case (selA0)
            CODE_0,
            CODE_1: stateD.t0Cap = portAPinIn[0] & portADir[0];
            CODE_2: begin
                stateD.padOe[0] = 1'b1;
                stateD.padOut[0] = timer0Output;
            end
            default: begin
                stateD.padOe[0] = 1'b0;
                stateD.padOut[0] = 1'b0;
                stateD.xtalA = 1'b1;
            end
        endcase
        // drive levels per pin, forced off unless the pin is a push-pull output
        for (int i = 0; i < 8; i++) begin
            stateD.drvF[2*i +: 2] = portFDir[i] ? DRIVE_OFF :
                (i >= 4 ? drv2[DRV_PF_HI_LSB +: 2] : drv2[DRV_PF_LO_LSB +: 2]);
            stateD.drvE[2*i +: 2] = portEDir[i] ? DRIVE_OFF :
                (i >= 4 ? drv2[DRV_PE_HI_LSB +: 2] : drv2[DRV_PE_LO_LSB +: 2]);
        end
        for (int i = 0; i < 3; i++) begin
            stateD.drvG[2*i +: 2] = portGDir[i] ? DRIVE_OFF : drv3[DRV_PG_LSB +: 2];
        end
    end

    // single state register; reset clears every register to zero and holds waitrequest high
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            stateQ <= '0;
            stateQ.regs <= {NUM_REGS{REG_RESET}};
            stateQ.waitReq <= 1'b1;
        end else begin
            stateQ <= stateD;
        end
    end

    // outputs are the flops themselves
    assign readdata = stateQ.rdData;
    assign waitrequest = stateQ.waitReq;
    assign portAPadOut = stateQ.padOut;
    assign portAPadOe = stateQ.padOe;
    assign timer1CaptureInput = stateQ.t1Cap;
    assign timer0ClockInput = stateQ.t0Clk;
    assign extInterruptInput = stateQ.extInt;
    assign stdTimerClockInput = stateQ.stdClk;
    assign timer0CaptureInput = stateQ.t0Cap;
    assign crystalPinAEn = stateQ.xtalA;
    assign crystalPinBEn = stateQ.xtalB;
    assign lcdSegmentEn = stateQ.lcdSeg;
    assign lowVoltageDetectEn = stateQ.lvd;
    assign portEDrive = stateQ.drvE;
    assign portFDrive = stateQ.drvF;
    assign portGDrive = stateQ.drvG;
    // input source selects and other ports' codes go to the peripheral and pad rings
    assign inputSourceSel0 = stateQ.regs[IDX_INPUT_SOURCE_SELECT_0];
    assign inputSourceSel1 = stateQ.regs[IDX_INPUT_SOURCE_SELECT_1];
    assign otherFuncSel = stateQ.regs[IDX_PORTG_FUNC_SELECT:IDX_PORTA_FUNC_SELECT_HIGH];

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    chk_drive_f_high: assert property (!portFDir[7] |=>
        portFDrive[15:14] == stateQ.regs[IDX_DRIVE_LEVEL_CTRL_2][7:6])
        else $error("port F upper drive level wrong");
    chk_drive_f_low: assert property (!$past(sys_rst) && !$past(portFDir[0]) |->
        portFDrive[1:0] == stateQ.regs[IDX_DRIVE_LEVEL_CTRL_2][5:4])
        else $error("port F lower drive level wrong");
    chk_drive_e_both: assert property (!$past(sys_rst) && !$past(portEDir[7])
        && !$past(portEDir[0]) |-> portEDrive[15:14] == stateQ.regs[IDX_DRIVE_LEVEL_CTRL_2][3:2]
        && portEDrive[1:0] == stateQ.regs[IDX_DRIVE_LEVEL_CTRL_2][1:0])
        else $error("port E drive level wrong");
    chk_drive_g_level: assert property (!$past(sys_rst) && !$past(portGDir[2]) |->
        portGDrive[5:4] == stateQ.regs[IDX_DRIVE_LEVEL_CTRL_2 + 4'h1][1:0])
        else $error("port G drive level wrong");
    chk_drive3_reserved: assert property (stateQ.regs[IDX_DRIVE_LEVEL_CTRL_3][7:2] == 6'h00)
        else $error("drive register 3 reserved bits set");
    chk_pin3_route: assert property (!$past(sys_rst)
        && stateQ.regs[IDX_PORTA_FUNC_SELECT_LOW][7:6] == CODE_1
        |-> portAPadOe[3] && portAPadOut[3] == $past(timer1Output))
        else $error("pin 3 not driven by timer 1 output");
    chk_pin2_crystal: assert property (!$past(sys_rst)
        |-> crystalPinBEn == (stateQ.regs[IDX_PORTA_FUNC_SELECT_LOW][5:4] == CODE_3)
        && !(crystalPinBEn && portAPadOe[2]))
        else $error("pin 2 crystal selection wrong");
    chk_pin1_detector: assert property (!$past(sys_rst)
        && stateQ.regs[IDX_PORTA_FUNC_SELECT_LOW][3:2] == CODE_2
        |-> lowVoltageDetectEn && !portAPadOe[1] && !lcdSegmentEn && !extInterruptInput)
        else $error("pin 1 detector selection wrong");
    chk_pin0_timer: assert property (!$past(sys_rst)
        && stateQ.regs[IDX_PORTA_FUNC_SELECT_LOW][1:0] == CODE_2
        |-> portAPadOe[0] && portAPadOut[0] == $past(timer0Output) && !timer0CaptureInput)
        else $error("pin 0 timer output selection wrong");
    chk_input_qualify: assert property (timer0CaptureInput |-> $past(portADir[0])
        && $past(portAPinIn[0]))
        else $error("capture input passed while pin is an output");
    chk_gpio_dir: assert property (!$past(sys_rst)
        && stateQ.regs[IDX_PORTA_FUNC_SELECT_LOW][1:0] == CODE_0
        |-> portAPadOe[0] == !$past(portADir[0]))
        else $error("gpio output enable does not follow direction");
    chk_drive_input: assert property (!$past(sys_rst) && $past(portFDir[3])
        |-> portFDrive[7:6] == DRIVE_OFF)
        else $error("drive level applied to an input pin");
    chk_write_lands: assert property (write && !waitrequest && address == 8'h08
        |=> stateQ.regs[IDX_PORTA_FUNC_SELECT_LOW] == $past(writedata[7:0]))
        else $error("write did not land in port A select");
    chk_wait_pulse: assert property ((read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
        else $error("waitrequest did not answer in one cycle");
    chk_reserved_zero: assert property (stateQ.regs[IDX_INPUT_SOURCE_SELECT_0][5:4] == 2'h0
        && stateQ.regs[IDX_PORTG_FUNC_SELECT][7:6] == 2'h0)
        else $error("reserved selection bits set");

    // routing checks per code; pads are registered, so peripheral levels are
    // compared one cycle late while the select code is the stored one

    // pin 3 serial data drives the pad
    chk_pin3_serial: assert property (stateQ.regs[IDX_PORTA_FUNC_SELECT_LOW][7:6] == CODE_2
        |-> portAPadOe[3] && portAPadOut[3] == $past(serialDataOut))
        else $error("pin 3 not driven by serial data");

    // pin 3 oscillator output drives the pad
    chk_pin3_osc: assert property (stateQ.regs[IDX_PORTA_FUNC_SELECT_LOW][7:6] == CODE_3
        |-> portAPadOe[3] && portAPadOut[3] == $past(oscOutPin))
        else $error("pin 3 not driven by oscillator");

    // capture input is dead unless pin 3 is in its gpio code
    chk_pin3_capture: assert property (stateQ.regs[IDX_PORTA_FUNC_SELECT_LOW][7:6] != CODE_0
        |-> !timer1CaptureInput)
        else $error("pin 3 capture input passed in a peripheral code");

    // a shared digital input only sees a pin set as input
    chk_t1_qualify: assert property (timer1CaptureInput |-> $past(portADir[3])
        && $past(portAPinIn[3]))
        else $error("timer 1 capture passed while pin is an output");

    // timer clock input: input pin and not on the crystal
    chk_t0clk_qualify: assert property (timer0ClockInput |-> $past(portADir[2])
        && stateQ.regs[IDX_PORTA_FUNC_SELECT_LOW][5:4] != CODE_3)
        else $error("timer 0 clock passed wrongly");

    // lcd segment is analog: the digital driver lets go
    chk_pin1_lcd: assert property (stateQ.regs[IDX_PORTA_FUNC_SELECT_LOW][3:2] == CODE_1
        |-> lcdSegmentEn && !portAPadOe[1] && !lowVoltageDetectEn)
        else $error("pin 1 lcd selection wrong");

    // inverted timer output drives pin 1
    chk_pin1_timer: assert property (stateQ.regs[IDX_PORTA_FUNC_SELECT_LOW][3:2] == CODE_3
        |-> portAPadOe[1] && portAPadOut[1] == $past(timer0InvertedOutput))
        else $error("pin 1 not driven by inverted timer output");

    // interrupt and timer clock share the gpio code of pin 1
    chk_pin1_inputs: assert property (extInterruptInput || stdTimerClockInput
        |-> stateQ.regs[IDX_PORTA_FUNC_SELECT_LOW][3:2] == CODE_0 && $past(portADir[1]))
        else $error("pin 1 inputs passed wrongly");

    // crystal on pin 0 releases the pad
    chk_pin0_crystal: assert property (stateQ.regs[IDX_PORTA_FUNC_SELECT_LOW][1:0] == CODE_3
        |-> crystalPinAEn && !portAPadOe[0])
        else $error("pin 0 crystal selection wrong");

    // code one is the second gpio code of pin 0
    chk_pin0_code1: assert property (stateQ.regs[IDX_PORTA_FUNC_SELECT_LOW][1:0] == CODE_1
        |-> !crystalPinAEn && timer0CaptureInput == ($past(portADir[0]) && $past(portAPinIn[0])))
        else $error("pin 0 code one routing wrong");

    // drive levels are meaningless on inputs, so they read off
    chk_drive_e_input: assert property ($past(portEDir[4]) |-> portEDrive[9:8] == DRIVE_OFF)
        else $error("port E drive level applied to an input pin");

    // same for port G
    chk_drive_g_input: assert property ($past(portGDir[0]) |-> portGDrive[1:0] == DRIVE_OFF)
        else $error("port G drive level applied to an input pin");

    // registers are one byte wide; the upper read lanes stay zero
    chk_readdata_upper: assert property (readdata[31:8] == 24'h000000)
        else $error("upper read data lanes not zero");

    // an unmapped read answers zero
    chk_unmapped_read: assert property (read && waitrequest && address[7:6] != 2'h0
        |=> readdata == '0)
        else $error("unmapped read returned data");

    // a mapped read returns the stored byte
    chk_read_data: assert property (read && waitrequest && address[7:6] == 2'h0
        |=> readdata[7:0] == $past(stateQ.regs[address[5:2]]))
        else $error("read data does not match register");

    // reserved bits of the port C and E selects stay clear
    chk_sel_reserved: assert property (stateQ.regs[IDX_PORTE_FUNC_SELECT_LOW][7:6] == 2'h0
        && stateQ.regs[IDX_PORTC_FUNC_SELECT_HIGH][7:4] == 4'h0)
        else $error("reserved port selection bits set");

endmodule

// ---- test/pfds_pin_model.sv ----
// behavioural model of the package pins and of the peripheral units that share them
`timescale 1ns/100ps
module pfds_pin_model (
    input  wire logic [3:0] portAPadOut,
    input  wire logic [3:0] portAPadOe,
    input  wire logic [3:0] extLevel,
    input  wire logic [4:0] periphLevel,
    output logic      [3:0] portAPinIn,
    output logic            timer1Output,
    output logic            serialDataOut,
    output logic            oscOutPin,
    output logic            timer0InvertedOutput,
    output logic            timer0Output
);
    // pad level: our driver wins where enabled, otherwise the board's own level
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            portAPinIn[i] = portAPadOe[i] ? portAPadOut[i] : extLevel[i];
        end
    end
    // peripheral outputs are plain levels, moved only once the pin is routed
    assign {timer1Output, serialDataOut, oscOutPin, timer0InvertedOutput, timer0Output} =
        periphLevel;
endmodule

// ---- test/test_pfds_pin_mux.sv ----
// self-checking bench for the pin function and drive-level block
`timescale 1ns/100ps
module test_pfds_pin_mux;
    import pfds_pkg::*;
    logic              ref_clk = 1'b0;
    logic              sys_rst = 1'b1;
    logic [ADDR_W-1:0] address = '0;
    logic              read = 1'b0;
    logic              write = 1'b0;
    logic [DATA_W-1:0] writedata = '0;
    logic [DATA_W-1:0] readdata;
    logic              waitrequest;
    logic [3:0]        portADir = 4'hF, portAOutData = 4'h0, extLevel = 4'h0;
    logic [3:0]        portAPinIn, portAPadOut, portAPadOe;
    logic [7:0]        portEDir = 8'hFF, portFDir = 8'hFF;
    logic [2:0]        portGDir = 3'h7;
    logic [4:0]        periphLevel = 5'h00;
    logic              timer1Output, serialDataOut, oscOutPin, timer0InvertedOutput, timer0Output;
    logic              timer1CaptureInput, timer0ClockInput, extInterruptInput;
    logic              stdTimerClockInput, timer0CaptureInput, crystalPinAEn, crystalPinBEn;
    logic              lcdSegmentEn, lowVoltageDetectEn;
    logic [15:0]       portEDrive, portFDrive;
    logic [5:0]        portGDrive;
    logic [7:0]        inputSourceSel0, inputSourceSel1;
    logic [87:0]       otherFuncSel;
    logic [16:0]       portAView;
    int                failCount = 0, testsRun = 0, cycles = 0;

    pfds_pin_mux pfds_pin_mux_i (.ref_clk, .sys_rst, .address, .read, .write, .writedata,
        .readdata, .waitrequest, .portADir, .portAOutData, .portAPinIn, .portEDir, .portFDir,
        .portGDir, .timer1Output, .serialDataOut, .oscOutPin, .timer0InvertedOutput,
        .timer0Output, .portAPadOut, .portAPadOe, .timer1CaptureInput, .timer0ClockInput,
        .extInterruptInput, .stdTimerClockInput, .timer0CaptureInput, .crystalPinAEn,
        .crystalPinBEn, .lcdSegmentEn, .lowVoltageDetectEn, .portEDrive, .portFDrive,
        .portGDrive, .inputSourceSel0, .inputSourceSel1, .otherFuncSel);
    pfds_pin_model pfds_pin_model_i (.portAPadOut, .portAPadOe, .extLevel, .periphLevel,
        .portAPinIn, .timer1Output, .serialDataOut, .oscOutPin, .timer0InvertedOutput,
        .timer0Output);

    // pad value is only meaningful where the pad is driven, so mask it by the enable
    assign portAView = {portAPadOe, portAPadOut & portAPadOe, timer1CaptureInput,
        timer0ClockInput, extInterruptInput, stdTimerClockInput, timer0CaptureInput,
        crystalPinAEn, crystalPinBEn, lcdSegmentEn, lowVoltageDetectEn};

    always #5 ref_clk = ~ref_clk;

    // a hung handshake ends the run here rather than never
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failCount++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", testsRun, failCount);
        if (failCount == 0 && testsRun > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [87:0] seen, input logic [87:0] exp);
        testsRun++;
        if (seen !== exp) begin
            failCount++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one access; held until waitrequest is sampled low, released after that edge
    task automatic bus_access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                              output logic [31:0] q);
        address <= a;
        writedata <= {24'h0, d};
        write <= wr;
        read <= ~wr;
        do @(posedge ref_clk); while (waitrequest !== 1'b0);
        q = readdata;
        write <= 1'b0;
        read <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus_access(1'b1, a, d, q);
    endtask

    task automatic rd_check(input string name, input logic [7:0] a, input logic [7:0] exp);
        logic [31:0] q;
        bus_access(1'b0, a, 8'h00, q);
        check(name, q, {24'h0, exp});
    endtask

    // outputs are registered; a few edges let the pad loop through the model settle
    task automatic settle();
        repeat (3) @(posedge ref_clk);
    endtask

    // port A pads and peripheral inputs expected for code c on all four pins
    function automatic logic [16:0] exp_a(input logic [1:0] c, input logic [3:0] dir, od, ext,
                                         input logic [4:0] p);
        logic [3:0] g, oe, po, pin;
        g = {c == 2'h0, c != 2'h3, c == 2'h0, c < 2'h2};
        oe = g & ~dir;
        po = g & ~dir & od;
        pin = g & dir & ext;
        if (c != 2'h0) begin
            oe[3] = 1'b1;
            po[3] = (c == 2'h1) ? p[4] : (c == 2'h2) ? p[3] : p[2];
        end
        if (c == 2'h3) begin
            oe[1] = 1'b1;
            po[1] = p[1];
        end
        if (c == 2'h2) begin
            oe[0] = 1'b1;
            po[0] = p[0];
        end
        return {oe, po, pin[3], pin[2], pin[1], pin[1], pin[0],
                c == 2'h3, c == 2'h3, c == 2'h1, c == 2'h2};
    endfunction

    initial begin
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        for (int i = 0; i < NUM_REGS; i++) begin
            rd_check("reset value", 8'(i * 4), REG_RESET);
        end
        $display("test reset values done");
        // all ones exposes which bits exist; the rest must read back zero
        for (int i = 0; i < NUM_REGS; i++) begin
            wr(8'(i * 4), 8'hFF);
            rd_check("write mask", 8'(i * 4), WR_MASK[i]);
        end
        check("input select 0", inputSourceSel0, WR_MASK[IDX_INPUT_SOURCE_SELECT_0]);
        check("input select 1", inputSourceSel1, WR_MASK[IDX_INPUT_SOURCE_SELECT_1]);
        check("output selects", otherFuncSel, WR_MASK[13:3]);
        // unmapped address that would alias register 0 if its top bits were dropped
        wr(8'h40, 8'h5A);
        rd_check("unmapped", 8'h40, 8'h00);
        rd_check("alias", 8'h00, WR_MASK[0]);
        $display("test register access done");
        portEDir <= 8'h00;
        portFDir <= 8'h80;
        portGDir <= 3'b010;
        wr(8'h00, 8'hE4);
        wr(8'h04, 8'hFF);
        settle();
        check("port F drive", portFDrive, 16'h3FAA);
        check("port E drive", portEDrive, 16'h5500);
        check("port G drive", portGDrive, 6'h33);
        portEDir <= 8'hFF;
        settle();
        check("port E input", portEDrive, 16'h0000);
        sys_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        rd_check("second reset", 8'h00, 8'h00);
        settle();
        check("drive after reset", portFDrive, 16'h0000);
        $display("test drive levels done");
        for (int c = 0; c < 4; c++) begin
            for (int k = 0; k < 4; k++) begin
                periphLevel <= 5'h00;
                wr(8'h08, {4{2'(c)}});
                portADir <= k[0] ? 4'hF : 4'h0;
                portAOutData <= k[1] ? 4'h5 : 4'hA;
                extLevel <= k[1] ? 4'h9 : 4'h6;
                periphLevel <= k[1] ? 5'h16 : 5'h09;
                settle();
                check("port A routing", portAView,
                      exp_a(2'(c), portADir, portAOutData, extLevel, periphLevel));
            end
        end
        $display("test port A routing done");
        report_and_stop();
    end
endmodule
